// file: dcd_consts.svh
// Purpose: shared constants for the command decoder link
// Assumes: ddr3-style command pins, one command per link clock edge
// Notes:   timing counts in link clock cycles
`ifndef DCD_CONSTS_SVH
`define DCD_CONSTS_SVH
`define DCD_BA_W        3
`define DCD_ADDR_W      14
`define DCD_A10         10
`define DCD_A12         12
`define DCD_WL_DEF      5
`define DCD_TXPDLL_DEF  10
`define DCD_TAONPD_MIN_PS 2000
`define DCD_TAONPD_MAX_PS 8500
`define DCD_TCK_PS      6000
// longest async delay rounded down, least rounded up, never below one
`define DCD_ASYNC_MAX_CYC ((`DCD_TAONPD_MAX_PS / `DCD_TCK_PS) < 1 ? 1 : \
                           (`DCD_TAONPD_MAX_PS / `DCD_TCK_PS))
`define DCD_ASYNC_MIN_CYC ((`DCD_TAONPD_MIN_PS + `DCD_TCK_PS - 1) / `DCD_TCK_PS)
`define DCD_CNT_W       8
`endif

// file: dcd_pkg.sv
// Purpose: types for the command decoder link
// Assumes: constants from dcd_consts.svh
// Notes:   command codes are shared by both ends
package dcd_pkg;
  typedef enum logic [3:0] {
    DCD_DES  = 4'h0,
    DCD_NOP  = 4'h1,
    DCD_MRS  = 4'h2,
    DCD_REF  = 4'h3,
    DCD_SRE  = 4'h4,
    DCD_ACT  = 4'h5,
    DCD_RD   = 4'h6,
    DCD_WR   = 4'h7,
    DCD_PRE  = 4'h8,
    DCD_ZQ   = 4'h9,
    DCD_PDE  = 4'ha,
    DCD_PDX  = 4'hb,
    DCD_ILL  = 4'hf
  } dcd_cmd_t;
  typedef enum logic [1:0] {
    DCD_ST_ACTIVE = 2'b00,
    DCD_ST_PDOWN  = 2'b01,
    DCD_ST_SREF   = 2'b11
  } dcd_pstate_t;
endpackage : dcd_pkg

// file: dcd_if.sv
// Purpose: command and termination pins between controller and memory
// Assumes: controller drives every pin, link clock made by controller
// Notes:   no two-way pins on this link
`timescale 1ns/100ps
`include "dcd_consts.svh"
interface dcd_if;
  logic                   ck;
  logic                   cke;
  logic                   cs_n;
  logic                   ras_n;
  logic                   cas_n;
  logic                   we_n;
  logic [`DCD_BA_W-1:0]   ba;
  logic [`DCD_ADDR_W-1:0] addr;
  logic                   odt;
  modport mem  (input ck, cke, cs_n, ras_n, cas_n, we_n, ba, addr, odt);
  modport ctrl (output ck, cke, cs_n, ras_n, cas_n, we_n, ba, addr, odt);
endinterface : dcd_if

// file: dcd_ctrl.sv
// Purpose: controller end, issues one command per link clock
// Assumes: user request is a one-cycle pulse, held fields stable with it
// Notes:   link clock is clock divided by two, driven out on ck
`timescale 1ns/100ps
`include "dcd_consts.svh"
module dcd_ctrl
  import dcd_pkg::*;
#(
  parameter int WL     = `DCD_WL_DEF,
  parameter int TXPDLL = `DCD_TXPDLL_DEF
)(
  input  wire logic                   clock,
  input  wire logic                   rst,
  input  wire logic                   req,
  input  wire dcd_cmd_t               req_cmd,
  input  wire logic [`DCD_BA_W-1:0]   req_ba,
  input  wire logic [`DCD_ADDR_W-1:0] req_addr,
  input  wire logic                   req_odt,
  output logic                        busy,
  output logic                        odt_uncertain,
  dcd_if.ctrl                         lnk
);
  logic                   ck_r;
  logic                   cke_r, cs_n_r, ras_n_r, cas_n_r, we_n_r, odt_r;
  logic [`DCD_BA_W-1:0]   ba_r;
  logic [`DCD_ADDR_W-1:0] addr_r;
  logic                   pend_r;
  dcd_cmd_t               pcmd_r;
  logic [`DCD_BA_W-1:0]   pba_r;
  logic [`DCD_ADDR_W-1:0] paddr_r;
  logic                   podt_r;
  logic [`DCD_CNT_W-1:0]  unc_r;
  logic                   busy_r, unc_o_r;
  wire                    launch = pend_r & ck_r; // change pins on falling ck
  wire                    cke_edge;
  wire [3:0]              pins;
  // pin pattern per command: cs_n ras_n cas_n we_n
  function automatic logic [3:0] dcd_pins(input dcd_cmd_t c);
    unique case (c)
      DCD_MRS: dcd_pins = 4'b0000;
      DCD_REF, DCD_SRE: dcd_pins = 4'b0001;
      DCD_ACT: dcd_pins = 4'b0011;
      DCD_RD:  dcd_pins = 4'b0101;
      DCD_WR:  dcd_pins = 4'b0100;
      DCD_PRE: dcd_pins = 4'b0010;
      DCD_ZQ:  dcd_pins = 4'b0110;
      DCD_NOP, DCD_PDE, DCD_PDX: dcd_pins = 4'b0111;
      default: dcd_pins = 4'b1111;
    endcase
  endfunction : dcd_pins
  assign pins     = dcd_pins(pcmd_r);
  assign cke_edge = launch & ((pcmd_r == DCD_PDE) | (pcmd_r == DCD_SRE) |
                              (pcmd_r == DCD_PDX));
  // divider makes the link clock
  always_ff @(posedge clock or posedge rst)
    if (rst) ck_r <= 1'b0;
    else     ck_r <= ~ck_r;
  // one pending request, launched at next falling ck
  always_ff @(posedge clock or posedge rst)
    if (rst)
    begin
      pend_r  <= 1'b0;
      pcmd_r  <= DCD_DES;
      pba_r   <= '0;
      paddr_r <= '0;
      podt_r  <= 1'b0;
    end
    else if (req & ~pend_r) // one command at a time, no burst cut short
    begin
      pend_r  <= 1'b1;
      pcmd_r  <= req_cmd;
      pba_r   <= req_ba;
      paddr_r <= req_addr;
      podt_r  <= req_odt;
    end
    else if (launch) pend_r <= 1'b0;
  // command pins; a deselect idles the bus between requests
  always_ff @(posedge clock or posedge rst)
    if (rst)
    begin
      cke_r   <= 1'b1;
      cs_n_r  <= 1'b1;
      ras_n_r <= 1'b1;
      cas_n_r <= 1'b1;
      we_n_r  <= 1'b1;
      ba_r    <= '0;
      addr_r  <= '0;
      odt_r   <= 1'b0;
    end
    else if (launch)
    begin
      {cs_n_r, ras_n_r, cas_n_r, we_n_r} <= pins;
      ba_r   <= pba_r;
      addr_r <= paddr_r; // bc and ap bits passed as given
      odt_r  <= podt_r;
      if (pcmd_r == DCD_PDE || pcmd_r == DCD_SRE) cke_r <= 1'b0;
      else if (pcmd_r == DCD_PDX)                 cke_r <= 1'b1;
    end
    else if (ck_r) {cs_n_r, ras_n_r, cas_n_r, we_n_r} <= 4'b1111;
  // uncertain window counted in clock cycles, two per link cycle, starting at each cke edge
  always_ff @(posedge clock or posedge rst)
    if (rst) unc_r <= '0;
    else if (cke_edge) unc_r <= 8'((WL - 1 + TXPDLL) * 2);
    else if (unc_r != '0) unc_r <= unc_r - 8'h01;
  always_ff @(posedge clock or posedge rst)
    if (rst)
    begin
      busy_r  <= 1'b0;
      unc_o_r <= 1'b0;
    end
    else
    begin
      busy_r  <= pend_r | (req & ~pend_r);
      unc_o_r <= (unc_r != '0) | cke_edge;
    end
  assign busy          = busy_r;
  assign odt_uncertain = unc_o_r;
  assign lnk.ck    = ck_r;
  assign lnk.cke   = cke_r;
  assign lnk.cs_n  = cs_n_r;
  assign lnk.ras_n = ras_n_r;
  assign lnk.cas_n = cas_n_r;
  assign lnk.we_n  = we_n_r;
  assign lnk.ba    = ba_r;
  assign lnk.addr  = addr_r;
  assign lnk.odt   = odt_r;
endmodule : dcd_ctrl

// file: dcd_mem.sv
// Purpose: memory end, decodes commands and drives termination state
// Contract
// - async windows only when dll freezes in power-down
// - exit window from tanpd before to txpdll after
// - tanpd is wl minus one cycles
// - turn-on bounded by min and max of both
// - turn-off bounded by min and max of both
// - short power-down: entry start to exit end
// - short idle: exit start to entry end
// - mode set, refresh, self-refresh entry decode
// - activate decode with bank and row
// - read decode with bank and column
// - write decode, same fields as read
// - read a12 low chop four, high eight
// - write a12 same burst encoding
// - a10 high means auto precharge
// - precharge decode, a10 selects all banks
// - zq decode, a10 long or short
// - nop and deselect decode
// - commands registered at rising link clock
// - controller never interrupts a burst
// - only nop or deselect on cke edges; the refresh pattern is also taken on a fall as self-refresh entry
// - async termination skips additive latency, 2 to 8.5 ns
// Assumes: link clock runs free; mode settings are user inputs
// Notes:   decoded command crosses to clock by toggle and handshake-free word
`timescale 1ns/100ps
`include "dcd_consts.svh"
module dcd_mem
  import dcd_pkg::*;
#(
  parameter int WL     = `DCD_WL_DEF,
  parameter int AL     = 0,
  parameter int TXPDLL = `DCD_TXPDLL_DEF
)(
  input  wire logic                   clock,
  input  wire logic                   rst,
  input  wire logic                   dll_freeze_cfg,
  input  wire logic                   otf_burst_cfg,
  dcd_if.mem                          lnk,
  output dcd_cmd_t                    cmd,
  output logic [`DCD_BA_W-1:0]        cmd_ba,
  output logic [`DCD_ADDR_W-1:0]      cmd_addr,
  output logic                        cmd_chop4,
  output logic                        cmd_autopre,
  output logic                        cmd_all_banks,
  output logic                        cmd_zq_long,
  output logic                        cmd_valid,
  output logic                        rtt_on,
  output logic                        in_window,
  output logic                        power_down
);
  // link domain registers
  logic                   cke_prev_r;
  dcd_cmd_t               lcmd_r;
  logic [`DCD_BA_W-1:0]   lba_r;
  logic [`DCD_ADDR_W-1:0] laddr_r;
  logic                   tgl_r;
  dcd_pstate_t            pst_r, pst_nxt;
  logic [`DCD_CNT_W-1:0]  win_r, win_nxt;
  logic [`DCD_CNT_W-1:0]  lat_r;
  logic                   frz_m_r, frz_r;
  logic                   rtt_l_r, async_r;
  logic [`DCD_CNT_W-1:0]  odt_hist_r;
  // clock domain registers
  logic [2:0]             tsync_r;
  logic [2:0]             rsync_r, wsync_r, psync_r;
  dcd_cmd_t               cmd_r;
  logic [`DCD_BA_W-1:0]   ba_o_r;
  logic [`DCD_ADDR_W-1:0] addr_o_r;
  logic                   c4_r, ap_r, ab_r, zl_r, val_r;
  wire                    act_pins = ~lnk.cs_n;
  wire [3:0]              rcw      = {lnk.cs_n, lnk.ras_n, lnk.cas_n, lnk.we_n};
  wire                    both_hi  = cke_prev_r & lnk.cke;
  wire                    pd_entry = cke_prev_r & ~lnk.cke;
  wire                    pd_exit  = ~cke_prev_r & lnk.cke;
  wire                    win_on   = frz_r & (pst_r == DCD_ST_PDOWN);
  wire                    sync_odt;
  wire                    new_rtt;
  dcd_cmd_t               dec;
  // full command decode from cke pair and control pins
  always_comb
  begin
    dec = DCD_ILL;
    if (pd_exit)
      dec = (rcw[3] | (rcw == 4'b0111)) ? DCD_PDX : DCD_ILL;
    else if (pd_entry)
      dec = (rcw == 4'b0001) ? DCD_SRE :
            (rcw[3] | (rcw == 4'b0111)) ? DCD_PDE : DCD_ILL;
    else if (~both_hi)
      dec = DCD_DES;
    else if (~act_pins)
      dec = DCD_DES;
    else
      unique case (rcw[2:0])
        3'b000: dec = DCD_MRS;
        3'b001: dec = DCD_REF;
        3'b011: dec = DCD_ACT;
        3'b101: dec = DCD_RD;
        3'b100: dec = DCD_WR;
        3'b010: dec = DCD_PRE;
        3'b110: dec = DCD_ZQ;
        3'b111: dec = DCD_NOP;
      endcase
  end
  // power state follows cke edges
  always_comb
  begin
    pst_nxt = pst_r;
    if (dec == DCD_SRE)      pst_nxt = DCD_ST_SREF;
    else if (dec == DCD_PDE) pst_nxt = DCD_ST_PDOWN;
    else if (pd_exit)        pst_nxt = DCD_ST_ACTIVE;
  end
  // window: exit holds it for txpdll, entry flagged on arrival
  always_comb
  begin
    win_nxt = (win_r != '0) ? win_r - 8'h01 : '0;
    if (pd_exit & frz_r)              win_nxt = 8'(TXPDLL);
    else if (pd_entry & frz_r)        win_nxt = 8'(WL - 1);
  end
  // sync path: odt delayed by write latency less two plus additive latency
  assign sync_odt = odt_hist_r[lat_r[2:0]];
  // async path: odt straight to rtt, no additive latency
  assign new_rtt  = (win_on | (win_r != '0)) ? lnk.odt : sync_odt;
  always_ff @(posedge lnk.ck or posedge rst)
    if (rst)
    begin
      frz_m_r <= 1'b0;
      frz_r   <= 1'b0;
    end
    else
    begin
      frz_m_r <= dll_freeze_cfg;
      frz_r   <= frz_m_r;
    end
  always_ff @(posedge lnk.ck or posedge rst)
    if (rst)
    begin
      cke_prev_r <= 1'b1; // idle cke level, so no false exit after reset
      pst_r      <= DCD_ST_ACTIVE;
      win_r      <= '0;
      lat_r      <= '0;
      odt_hist_r <= '0;
      rtt_l_r    <= 1'b0;
      async_r    <= 1'b0;
    end
    else
    begin
      cke_prev_r <= lnk.cke;
      pst_r      <= pst_nxt;
      win_r      <= win_nxt; // tanpd back-count folded into entry
      lat_r      <= 8'(WL - 2 + AL);
      odt_hist_r <= {odt_hist_r[`DCD_CNT_W-2:0], lnk.odt};
      rtt_l_r    <= (pst_r == DCD_ST_SREF) ? 1'b0 : new_rtt;
      async_r    <= win_on | (win_r != '0);
    end
  // command word held in link domain, toggle announces it
  always_ff @(posedge lnk.ck or posedge rst)
    if (rst)
    begin
      lcmd_r  <= DCD_DES;
      lba_r   <= '0;
      laddr_r <= '0;
      tgl_r   <= 1'b0;
    end
    else if (dec != DCD_DES && dec != DCD_NOP)
    begin
      lcmd_r  <= dec;
      lba_r   <= lnk.ba;
      laddr_r <= lnk.addr;
      tgl_r   <= ~tgl_r;
    end
  // crossings: toggle and levels through three flops each
  always_ff @(posedge clock or posedge rst)
    if (rst)
    begin
      tsync_r <= '0;
      rsync_r <= '0;
      wsync_r <= '0;
      psync_r <= '0;
    end
    else
    begin
      tsync_r <= {tsync_r[1:0], tgl_r};
      rsync_r <= {rsync_r[1:0], rtt_l_r};
      wsync_r <= {wsync_r[1:0], async_r};
      psync_r <= {psync_r[1:0], pst_r != DCD_ST_ACTIVE};
    end
  // word is stable long before toggle arrives, so sample it then
  always_ff @(posedge clock or posedge rst)
    if (rst)
    begin
      cmd_r    <= DCD_DES;
      ba_o_r   <= '0;
      addr_o_r <= '0;
      c4_r     <= 1'b0;
      ap_r     <= 1'b0;
      ab_r     <= 1'b0;
      zl_r     <= 1'b0;
      val_r    <= 1'b0;
    end
    else
    begin
      val_r <= tsync_r[2] ^ tsync_r[1];
      if (tsync_r[2] ^ tsync_r[1])
      begin
        cmd_r    <= lcmd_r;
        ba_o_r   <= lba_r;
        addr_o_r <= laddr_r;
        c4_r     <= otf_burst_cfg & ~laddr_r[`DCD_A12];
        ap_r     <= laddr_r[`DCD_A10];
        ab_r     <= laddr_r[`DCD_A10];
        zl_r     <= laddr_r[`DCD_A10];
      end
    end
  assign cmd           = cmd_r;
  assign cmd_ba        = ba_o_r;
  assign cmd_addr      = addr_o_r;
  assign cmd_chop4     = c4_r;
  assign cmd_autopre   = ap_r;
  assign cmd_all_banks = ab_r;
  assign cmd_zq_long   = zl_r;
  assign cmd_valid     = val_r;
  assign rtt_on        = rsync_r[2];
  assign in_window     = wsync_r[2];
  assign power_down    = psync_r[2];
endmodule : dcd_mem

// file: dcd_monitor.sv
// Purpose: wire checks on the command pins between the two ends
// Assumes: commands sampled at rising link clock, rst active high
// Notes:   sees only link signals, so user-side fields are judged by tb
`timescale 1ns/100ps
module dcd_monitor (
  input wire logic ck,
  input wire logic rst,
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n
);
  // nop or deselect are the only safe patterns around a cke edge, plus refresh on a fall for self-refresh entry
  wire idle_cmd = cs_n | (ras_n & cas_n & we_n);
  wire ref_cmd  = ~cs_n & ~ras_n & ~cas_n & we_n;

  default clocking @(posedge ck);
  endclocking
  default disable iff (rst);

  AST_PDX_IDLE: assert property ($rose(cke) |-> idle_cmd)
    else $error("command issued on cke rise");
  AST_PDE_IDLE: assert property ($fell(cke) |-> idle_cmd || ref_cmd)
    else $error("bad command on cke fall");
  AST_CMD_CKE_HIGH: assert property (!idle_cmd && cke |-> $past(cke))
    else $error("command without cke high on both edges");
  AST_NO_CMD_LOW: assert property (!cke && !$past(cke) |-> idle_cmd)
    else $error("command while powered down");
  AST_PD_HOLD: assert property ($fell(cke) |=> !cke)
    else $error("cke low not held");
  AST_PU_HOLD: assert property ($rose(cke) |=> cke)
    else $error("cke high not held");
  // self refresh entry must be reached at least once
  COV_SRE: cover property ($fell(cke) && ref_cmd);
endmodule : dcd_monitor

// file: tb.sv
// Purpose: bench joining controller and memory ends over the link
// Assumes: one command in flight, next only after the decode lands
// Notes:   expectations come from pin encodings, never from design output
`timescale 1ns/100ps
`include "dcd_consts.svh"
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin num_errors++; \
  $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module tb
  import dcd_pkg::*;
;
  logic                   clock, rst, req, req_odt, dll_freeze_cfg, otf_burst_cfg;
  dcd_cmd_t               req_cmd, cmd;
  logic [`DCD_BA_W-1:0]   req_ba, cmd_ba;
  logic [`DCD_ADDR_W-1:0] req_addr, cmd_addr;
  logic                   busy, odt_uncertain, cmd_chop4, cmd_autopre, cmd_all_banks;
  logic                   cmd_zq_long, cmd_valid, rtt_on, in_window, power_down;
  logic [3:0]             watch;
  int                     num_errors = 0;
  int                     checks_done = 0;

  dcd_if lnk ();
  // one vector so a single wait task serves every level
  assign watch = {rtt_on, in_window, power_down, cmd_valid};

  dcd_ctrl i_dcd_ctrl (.clock(clock), .rst(rst), .req(req), .req_cmd(req_cmd),
    .req_ba(req_ba), .req_addr(req_addr), .req_odt(req_odt), .busy(busy),
    .odt_uncertain(odt_uncertain), .lnk(lnk));
  dcd_mem i_dcd_mem (.clock(clock), .rst(rst), .dll_freeze_cfg(dll_freeze_cfg),
    .otf_burst_cfg(otf_burst_cfg), .lnk(lnk), .cmd(cmd), .cmd_ba(cmd_ba),
    .cmd_addr(cmd_addr), .cmd_chop4(cmd_chop4), .cmd_autopre(cmd_autopre),
    .cmd_all_banks(cmd_all_banks), .cmd_zq_long(cmd_zq_long), .cmd_valid(cmd_valid),
    .rtt_on(rtt_on), .in_window(in_window), .power_down(power_down));
  dcd_monitor i_dcd_monitor (.ck(lnk.ck), .rst(rst), .cke(lnk.cke), .cs_n(lnk.cs_n),
    .ras_n(lnk.ras_n), .cas_n(lnk.cas_n), .we_n(lnk.we_n));

  // 250 MHz main clock
  initial
  begin
    clock = 0;
    forever #2 clock = ~clock;
  end

  task automatic summarize;
    if (num_errors == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : summarize

  // bounded wait on one watched level, sampled mid-cycle
  task automatic wait_for(input int sel, input logic v, output bit ok);
    ok = 0;
    for (int i = 0; i < 80 && !ok; i++)
    begin
      @(negedge clock);
      ok = (watch[sel] === v);
    end
  endtask : wait_for

  // request held one cycle; a busy controller would drop it silently
  task automatic issue(input dcd_cmd_t c, input logic [`DCD_BA_W-1:0] b,
                       input logic [`DCD_ADDR_W-1:0] a, input logic o);
    for (int i = 0; i < 50 && busy !== 1'h0; i++) // never cut a command short
      @(negedge clock);
    req_cmd = c;
    req_ba = b;
    req_addr = a;
    req_odt = o;
    req = 1;
    @(negedge clock);
    req = 0;
  endtask : issue

  task automatic do_cmd(input dcd_cmd_t c, input logic [`DCD_BA_W-1:0] b,
                        input logic [`DCD_ADDR_W-1:0] a);
    bit ok;
    issue(c, b, a, req_odt);
    wait_for(0, 1'h1, ok);
    `CHK("cmd_valid", 1'h1, ok)
    `CHK("cmd", c, cmd)
  endtask : do_cmd

  task automatic t_fields;
    do_cmd(DCD_MRS, 3'h5, 14'h1a5c);
    `CHK("mrs ba", 3'h5, cmd_ba)
    `CHK("mrs op", 14'h1a5c, cmd_addr)
    do_cmd(DCD_REF, 3'h0, 14'h0000);
    do_cmd(DCD_ACT, 3'h7, 14'h3fff);
    `CHK("act ba", 3'h7, cmd_ba)
    `CHK("act row", 14'h3fff, cmd_addr)
  endtask : t_fields

  // every read/write mix of burst and auto precharge bits
  task automatic t_rw;
    logic [`DCD_ADDR_W-1:0] a;
    for (int i = 0; i < 8; i++)
    begin
      a = {1'h0, i[1], 1'h0, i[0], 10'h2a0 + 10'(i)};
      do_cmd(i[2] ? DCD_WR : DCD_RD, 3'(i), a);
      `CHK("rw col", a[9:0], cmd_addr[9:0])
      `CHK("rw ba", 3'(i), cmd_ba)
      `CHK("chop4", ~i[1], cmd_chop4)
      `CHK("autopre", i[0], cmd_autopre)
    end
    otf_burst_cfg = 0;
    do_cmd(DCD_RD, 3'h1, 14'h0000);
    `CHK("fixed chop4", 1'h0, cmd_chop4)
    otf_burst_cfg = 1;
  endtask : t_rw

  task automatic t_pre_zq;
    for (int i = 0; i < 2; i++)
    begin
      do_cmd(DCD_PRE, 3'h2, {3'h0, i[0], 10'h000});
      `CHK("all banks", i[0], cmd_all_banks)
      `CHK("pre ba", 3'h2, cmd_ba)
      do_cmd(DCD_ZQ, 3'h0, {3'h7, i[0], 10'h3ff});
      `CHK("zq long", i[0], cmd_zq_long)
    end
  endtask : t_pre_zq

  // nop and deselect must not reach the user side; odt here takes the latency path
  task automatic t_idle;
    bit ok;
    issue(DCD_NOP, 3'h0, 14'h0000, 1'h1);
    wait_for(0, 1'h1, ok);
    `CHK("nop silent", 1'h0, ok)
    `CHK("sync rtt on", 1'h1, rtt_on)
    issue(DCD_DES, 3'h0, 14'h0000, 1'h0);
    wait_for(0, 1'h1, ok);
    `CHK("des silent", 1'h0, ok)
    `CHK("sync rtt off", 1'h0, rtt_on)
  endtask : t_idle

  // power-down round trip; windows only exist with the dll frozen
  task automatic t_power(input logic f);
    bit ok;
    dll_freeze_cfg = f;
    repeat (8) @(negedge clock); // freeze setting must cross before entry
    issue(DCD_PDE, 3'h0, 14'h0000, 1'h0);
    wait_for(1, 1'h1, ok);
    `CHK("pd entered", 1'h1, ok)
    repeat (4) @(negedge clock); // window flag trails power state by a link cycle
    `CHK("pd window", f, in_window)
    if (f)
    begin
      issue(DCD_NOP, 3'h0, 14'h0000, 1'h1);
      wait_for(3, 1'h1, ok);
      `CHK("rtt on", 1'h1, ok)
      issue(DCD_NOP, 3'h0, 14'h0000, 1'h0);
      wait_for(3, 1'h0, ok);
      `CHK("rtt off", 1'h1, ok)
    end
    issue(DCD_PDX, 3'h0, 14'h0000, 1'h0);
    repeat (2) @(negedge clock); // pins launch up to two clocks after the take
    `CHK("ctrl uncertain", 1'h1, odt_uncertain)
    wait_for(1, 1'h0, ok);
    `CHK("pd left", 1'h1, ok)
    `CHK("exit window", f, in_window)
    wait_for(2, 1'h0, ok);
    `CHK("window closed", 1'h1, ok)
    repeat (32) @(negedge clock); // controller count outlasts the memory window
    `CHK("ctrl settled", 1'h0, odt_uncertain)
  endtask : t_power

  task automatic t_sref;
    do_cmd(DCD_SRE, 3'h0, 14'h0000);
  endtask : t_sref

  initial
  begin
    rst = 1;
    req = 0;
    req_cmd = DCD_NOP;
    req_ba = 0;
    req_addr = 0;
    req_odt = 0;
    dll_freeze_cfg = 0;
    otf_burst_cfg = 1;
    repeat (10) @(negedge clock);
    rst = 0;
    t_fields();
    t_rw();
    t_pre_zq();
    t_idle();
    t_power(1'h1);
    t_power(1'h0);
    t_sref();
    summarize();
  end

  // whole run is a few hundred cycles; this is far past that
  initial
  begin
    #200000;
    num_errors++;
    summarize();
  end
endmodule : tb
